// File: hdl/lpuart_tx_pkg.sv
// Package for the low-energy serial port transmitter: register map, fields, reset values, carrier types.
// Assumes a single 100 MHz port clock and a 32-bit AHB-Lite register bus.
package lpuart_tx_pkg;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_DIVIDER = 8'h0C;
  localparam logic [7:0] OFS_IFLAG = 8'h10;
  localparam logic [7:0] OFS_IMASK = 8'h14;
  localparam logic [7:0] OFS_TXBASIC = 8'h18;
  localparam logic [7:0] OFS_TXEXT = 8'h1C;
  // Control register fields
  localparam int CTRL_NINEBIT_POS = 0;
  localparam int CTRL_BIT8DEF_POS = 1;
  localparam int CTRL_IDLELOW_POS = 2;
  // Command register fields
  localparam int CMD_TX_ENABLE_CMD_POS = 0;
  localparam int CMD_TX_DISABLE_CMD_POS = 1;
  // Status register fields
  localparam int STAT_TX_ENABLED_STATUS_POS = 0;
  localparam int STAT_TXC_POS = 1;
  localparam int STAT_TXBFULL_POS = 2;
  // Interrupt flag / mask field
  localparam int IF_TXC_POS = 0;
  // Extended data port: bit 8 is the ninth bit
  localparam int TXEXT_BIT8_POS = 8;
  // Divider layout: integer bits 14:8, fraction bits 7:3
  localparam int DIV_LSB = 3;
  localparam int DIV_MSB = 14;
  localparam int DIV_WIDTH = 12;
  localparam int FRAC_WIDTH = 5;
  localparam int INT_WIDTH = 7;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [11:0] DIV_RESET = 12'h000;
  localparam logic IMASK_RESET = 1'b0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } frame_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
endpackage

// File: hdl/lpuart_tx.sv
// Transmit path and fractional baud generator of a low-energy serial port, AHB-Lite slave.
// Assumes a single clock ref_clk, synchronous active-high reset, one master, word accesses.
//
// Overview of operation
// - Baud divider is twelve bits: seven integer, five fraction.
// - Integer part right-aligned in upper 24 bits, fraction left-aligned in lower eight.
// - Bit rate is clock over one plus divider register over 256.
// - Empty shifter loads a buffered frame; shifting starts only while enabled.
// - After a frame, next buffered frame loads at once, else idle.
// - Command enable bit enables transmission, disable bit disables it.
// - Disable aborts ongoing transmission at once and discards the frame.
// - Disabled transmitter holds TX at idle level, high by default.
// - Read-only status bit 0 shows whether the transmitter is enabled.
// - Transmission ending with shifter and buffer empty sets complete flags.
// - Complete status clears when new data arrives; interrupt flag needs software.
// - Basic port writes eight bits; ninth bit comes from control default.
// - Extended port supplies ninth bit directly, overriding the default.
`timescale 1ns/1ps
module lpuart_tx
  import lpuart_tx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic txOut,
  output logic irq
);

  bus_req_type req_r;
  logic [2:0] ctrl_r;
  logic [11:0] div_r;
  logic tx_enable_cmd_r;
  frame_type buf_r;
  logic bufFull_r;
  frame_type shift_r;
  logic shiftFull_r;
  tx_state_type state_r;
  logic [3:0] bitIdx_r;
  logic [7:0] baudCnt_r;
  logic [FRAC_WIDTH-1:0] fracAcc_r;
  logic txc_r;
  logic txcIf_r;
  logic imask_r;
  logic txOut_r;
  logic [31:0] hrdata_r;
  logic wrCtrl, wrCmd, wrDiv, wrMask, wrBasic, wrExt, rdIf;
  logic bitEnd, extraCycle, frameDone, loadShift, doDisable;
  logic [FRAC_WIDTH:0] fracSum;
  logic [INT_WIDTH-1:0] divInt;
  logic [FRAC_WIDTH-1:0] divFrac;
  logic [3:0] lastBit;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign txOut = txOut_r;

  // Address phase capture; data phase acts one cycle later with zero wait states
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      req_r <= '0;
    else if (hready)
    begin
      req_r.addr <= haddr[7:0];
      req_r.wr <= hsel && htrans[1] && hwrite;
      req_r.rd <= hsel && htrans[1] && !hwrite;
    end
    else
    begin
      req_r.wr <= 1'b0;
      req_r.rd <= 1'b0;
    end
  end

  assign wrCtrl = req_r.wr && req_r.addr == OFS_CONTROL;
  assign wrCmd = req_r.wr && req_r.addr == OFS_COMMAND;
  assign wrDiv = req_r.wr && req_r.addr == OFS_DIVIDER;
  assign wrMask = req_r.wr && req_r.addr == OFS_IMASK;
  assign wrBasic = req_r.wr && req_r.addr == OFS_TXBASIC;
  assign wrExt = req_r.wr && req_r.addr == OFS_TXEXT;
  assign rdIf = req_r.rd && req_r.addr == OFS_IFLAG;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ctrl_r <= CTRL_RESET;
    else if (wrCtrl)
      ctrl_r <= hwdata[2:0];
  end

  // twelve-bit divider taken from its register position
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      div_r <= DIV_RESET;
    else if (wrDiv)
      // integer right-aligned from bit 8 up, fraction at the top of the low byte
      div_r <= hwdata[DIV_MSB:DIV_LSB];
  end

  assign divInt = div_r[DIV_WIDTH-1:FRAC_WIDTH];
  assign divFrac = div_r[FRAC_WIDTH-1:0];

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      imask_r <= IMASK_RESET;
    else if (wrMask)
      imask_r <= hwdata[IF_TXC_POS];
  end

  // enable and disable commands; disable wins if both are written
  assign doDisable = wrCmd && hwdata[CMD_TX_DISABLE_CMD_POS];
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      tx_enable_cmd_r <= 1'b0;
    else if (doDisable)
      tx_enable_cmd_r <= 1'b0;
    else if (wrCmd && hwdata[CMD_TX_ENABLE_CMD_POS])
      tx_enable_cmd_r <= 1'b1;
  end

  // Transmit buffer, one frame deep; a write to a full buffer overwrites it
  assign loadShift = bufFull_r && !shiftFull_r;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      buf_r <= '0;
      bufFull_r <= 1'b0;
    end
    else if (wrExt)
    begin
      // ninth bit from the extended port itself
      buf_r.data <= hwdata[7:0];
      buf_r.ninth <= hwdata[TXEXT_BIT8_POS];
      bufFull_r <= 1'b1;
    end
    else if (wrBasic)
    begin
      // ninth bit from the control default
      buf_r.data <= hwdata[7:0];
      buf_r.ninth <= ctrl_r[CTRL_BIT8DEF_POS];
      bufFull_r <= 1'b1;
    end
    else if (loadShift)
      bufFull_r <= 1'b0;
  end

  // each bit lasts divInt+1 clocks, one more when the fraction carries
  // fraction accumulator spreads the extra cycles across bits
  assign fracSum = {1'b0, fracAcc_r} + {1'b0, divFrac};
  assign extraCycle = fracSum[FRAC_WIDTH];
  assign bitEnd = (state_r != TX_IDLE)
    && (baudCnt_r == ({1'b0, divInt} + {7'h00, extraCycle}));
  assign lastBit = ctrl_r[CTRL_NINEBIT_POS] ? 4'h8 : 4'h7;
  assign frameDone = bitEnd && state_r == TX_STOP;

  always_ff @(posedge ref_clk)
  begin
    if (srst || doDisable || state_r == TX_IDLE || bitEnd)
      baudCnt_r <= 8'h00;
    else
      baudCnt_r <= baudCnt_r + 8'h01;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      fracAcc_r <= '0;
    else if (bitEnd)
      fracAcc_r <= fracSum[FRAC_WIDTH-1:0];
  end

  // Shift register and frame sequencer
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      shift_r <= '0;
      shiftFull_r <= 1'b0;
      state_r <= TX_IDLE;
      bitIdx_r <= 4'h0;
    end
    // abort and drop the frame in the shifter
    else if (doDisable)
    begin
      shiftFull_r <= 1'b0;
      state_r <= TX_IDLE;
      bitIdx_r <= 4'h0;
    end
    else
    begin
      unique case (state_r)
        TX_IDLE:
        begin
          // load when empty, start only while enabled
          if (loadShift)
          begin
            shift_r <= buf_r;
            shiftFull_r <= 1'b1;
          end
          else if (shiftFull_r && tx_enable_cmd_r)
            state_r <= TX_START;
        end
        TX_START:
          if (bitEnd)
          begin
            state_r <= TX_DATA;
            bitIdx_r <= 4'h0;
          end
        TX_DATA:
          if (bitEnd)
          begin
            if (bitIdx_r == lastBit)
              state_r <= TX_STOP;
            bitIdx_r <= bitIdx_r + 4'h1;
          end
        TX_STOP:
          // finished frame empties the shifter; next one loads in idle at once
          if (bitEnd)
          begin
            shiftFull_r <= 1'b0;
            state_r <= TX_IDLE;
          end
      endcase
    end
  end

  // start low, data LSB first, ninth bit only in nine-bit mode, stop high
  // idle level while disabled or idle, high unless inverted in control
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      txOut_r <= 1'b1;
    else
    begin
      unique case (state_r)
        TX_START: txOut_r <= 1'b0;
        TX_DATA: txOut_r <= (bitIdx_r == 4'h8) ? shift_r.ninth : shift_r.data[bitIdx_r[2:0]];
        TX_STOP: txOut_r <= 1'b1;
        TX_IDLE: txOut_r <= !ctrl_r[CTRL_IDLELOW_POS];
      endcase
      if (doDisable)
        txOut_r <= !ctrl_r[CTRL_IDLELOW_POS];
    end
  end

  // complete status set when the last frame ends with nothing queued
  // status cleared by new data; new data wins over set
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      txc_r <= 1'b0;
    else if (frameDone && !bufFull_r && !wrBasic && !wrExt)
      txc_r <= 1'b1;
    else if (wrBasic || wrExt)
      txc_r <= 1'b0;
  end

  // sticky interrupt flag; read clears, a new event in the same cycle wins
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      txcIf_r <= 1'b0;
    else if (frameDone && !bufFull_r && !wrBasic && !wrExt)
      txcIf_r <= 1'b1;
    // Clear only a flag that the read returned; an event after the address phase is kept
    else if (rdIf && hrdata_r[IF_TXC_POS])
      txcIf_r <= 1'b0;
  end

  assign irq = txcIf_r && imask_r;

  // Read data registered in the address phase so it stands in the data phase
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      hrdata_r <= RDATA_ZERO;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      hrdata_r <= RDATA_ZERO;
      unique case (haddr[7:0])
        OFS_CONTROL: hrdata_r[2:0] <= ctrl_r;
        OFS_STATUS: hrdata_r[2:0] <= {bufFull_r, txc_r, tx_enable_cmd_r};
        OFS_DIVIDER: hrdata_r[DIV_MSB:DIV_LSB] <= div_r;
        OFS_IFLAG: hrdata_r[IF_TXC_POS] <= txcIf_r;
        OFS_IMASK: hrdata_r[IF_TXC_POS] <= imask_r;
        default: hrdata_r <= RDATA_ZERO;
      endcase
    end
  end

  // Cover of main scenarios
  cov_frame_done: cover property (@(posedge ref_clk) disable iff (srst) frameDone);
  cov_abort: cover property (@(posedge ref_clk) disable iff (srst) doDisable && state_r == TX_DATA);
  cov_back_to_back: cover property (@(posedge ref_clk) disable iff (srst) frameDone && bufFull_r);

  chk_disable_aborts: assert property (@(posedge ref_clk) disable iff (srst)
    doDisable |=> state_r == TX_IDLE && !shiftFull_r && !tx_enable_cmd_r)
    else $error("disable did not abort");
  chk_enable_status: assert property (@(posedge ref_clk) disable iff (srst)
    wrCmd && hwdata[CMD_TX_ENABLE_CMD_POS] && !hwdata[CMD_TX_DISABLE_CMD_POS] |=> tx_enable_cmd_r)
    else $error("enable not taken");
  chk_idle_level: assert property (@(posedge ref_clk) disable iff (srst)
    !tx_enable_cmd_r && $past(!tx_enable_cmd_r) && state_r == TX_IDLE |-> txOut_r == !$past(ctrl_r[CTRL_IDLELOW_POS]))
    else $error("tx not idle while disabled");
  chk_no_start_disabled: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TX_IDLE && !tx_enable_cmd_r |=> state_r == TX_IDLE)
    else $error("started while disabled");
  chk_start_low: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TX_START && $past(state_r) == TX_START |-> !txOut_r)
    else $error("start bit not low");
  chk_stop_high: assert property (@(posedge ref_clk) disable iff (srst)
    state_r == TX_STOP && $past(state_r) == TX_STOP |-> txOut_r)
    else $error("stop bit not high");
  chk_txc_set: assert property (@(posedge ref_clk) disable iff (srst)
    frameDone && !bufFull_r && !wrBasic && !wrExt |=> txc_r && txcIf_r)
    else $error("complete flags not set");
  chk_txc_clear: assert property (@(posedge ref_clk) disable iff (srst)
    (wrBasic || wrExt) |=> !txc_r)
    else $error("complete status not cleared");
  chk_basic_ninth: assert property (@(posedge ref_clk) disable iff (srst)
    wrBasic && !wrExt |=> buf_r.ninth == $past(ctrl_r[CTRL_BIT8DEF_POS]) && bufFull_r)
    else $error("basic port ninth bit wrong");
  chk_ext_ninth: assert property (@(posedge ref_clk) disable iff (srst)
    wrExt |=> buf_r.ninth == $past(hwdata[TXEXT_BIT8_POS]))
    else $error("extended port ninth bit wrong");
  chk_bit_length: assert property (@(posedge ref_clk) disable iff (srst)
    bitEnd |-> baudCnt_r >= {1'b0, divInt} && baudCnt_r <= {1'b0, divInt} + 8'h01)
    else $error("bit length off");
  chk_irq_mask: assert property (@(posedge ref_clk) disable iff (srst)
    irq |-> txcIf_r && imask_r)
    else $error("irq without unmasked flag");

endmodule // lpuart_tx

// File: tb/serial_frame_receiver.sv
// Behavioural serial receiver standing on the transmit line of the serial port.
// Assumes the bench gives the bit period in eighths of a clock and the frame length.
`timescale 1ns/1ps
module serial_frame_receiver
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic txLine,
  input wire logic nineBits,
  input wire logic [15:0] periodX8,
  output logic frameValid,
  output logic [9:0] frameWord
);
  logic [10:0] bits;
  int t;
  int nb;
  initial
  begin
    frameValid = 1'b0;
    frameWord = 10'h000;
    bits = 11'h000;
    forever
    begin
      @(posedge ref_clk);
      frameValid <= 1'b0;
      if (srst === 1'b0 && txLine === 1'b0)
      begin
        t = 0;
        nb = nineBits ? 9 : 8;
        for (int k = 0; k <= nb + 1; k++)
        begin
          while (t * 16 < (2 * k + 1) * periodX8) begin @(posedge ref_clk); t++; end
          bits[k] = txLine;
        end
        // Short low pulses are glitches, not frames
        if (bits[0] === 1'b0)
        begin
          frameWord <= {bits[nb + 1] === 1'b1, nb == 9 ? bits[9] : 1'b0, bits[8:1]};
          frameValid <= 1'b1;
        end
      end
    end
  end
endmodule // serial_frame_receiver

// File: tb/lpuart_tx_tb.sv
// Self-checking bench for the serial port transmitter with a receiver model on its line.
// Assumes one master on AHB-Lite, zero-wait slave, single word transfers.
`timescale 1ns/1ps
module lpuart_tx_tb;
  import lpuart_tx_pkg::*;
  logic ref_clk, srst, hsel, hwrite, hready, hreadyout, hresp, txOut, irq, nineBits, frameValid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] periodX8;
  logic [9:0] frameWord;
  logic [9:0] expQ[$];
  logic [7:0] d;
  int failures, comparisons;
  assign hready = hreadyout;
  lpuart_tx i_lpuart_tx (.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txOut(txOut), .irq(irq));
  serial_frame_receiver i_serial_frame_receiver (.ref_clk(ref_clk), .srst(srst), .txLine(txOut),
    .nineBits(nineBits), .periodX8(periodX8), .frameValid(frameValid), .frameWord(frameWord));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic give_verdict;
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic busXfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= wr ? wd : 32'h0000_0000;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] wd);
    busXfer(1'b1, a, wd);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    busXfer(1'b0, a, 32'h0000_0000);
    check(rd & m, exp);
    check({30'h0, hresp, hreadyout}, 32'h1);
  endtask
  task automatic sendFrame(input logic ext, input logic ninthExp, input logic [8:0] v);
    wrReg(ext ? OFS_TXEXT : OFS_TXBASIC, {23'h00_0000, v});
    expQ.push_back({1'b1, ninthExp, v[7:0]});
  endtask
  // Waits on the receiver, the watchdog bounds the wait
  task automatic drain;
    while (expQ.size() != 0) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
  endtask
  always @(posedge ref_clk)
  begin
    if (frameValid === 1'b1)
    begin
      if (expQ.size() == 0) check({22'h00_0000, frameWord}, 32'hFFFF_FFFF);
      else check({22'h00_0000, frameWord}, {22'h00_0000, expQ.pop_front()});
    end
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    give_verdict;
  end
  initial
  begin
    srst = 1'b1; hsel = 1'b1; hsize = 3'h2; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; nineBits = 1'b0; periodX8 = 16'h0080; failures = 0; comparisons = 0; rd = 32'h0;
    void'($urandom(74335));
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    check({31'h0, txOut}, 32'h1);
    rdChk(8'h40, 32'hFFFF_FFFF, 32'h0);
    rdChk(OFS_CONTROL, 32'hFFFF_FFFF, {29'h0, CTRL_RESET});
    rdChk(OFS_STATUS, 32'h1, 32'h0);
    wrReg(OFS_DIVIDER, 32'hFFFF_FFFF);
    rdChk(OFS_DIVIDER, 32'hFFFF_FFFF, 32'h0000_7FF8);
    // Sixteen clocks a bit
    wrReg(OFS_DIVIDER, 32'h0000_0F00);
    wrReg(OFS_IMASK, 32'h1);
    d = 8'($urandom);
    wrReg(OFS_TXBASIC, {24'h0, d});
    repeat (300) @(posedge ref_clk);
    wrReg(OFS_COMMAND, 32'h1);
    expQ.push_back({2'b10, d});
    rdChk(OFS_STATUS, 32'h1, 32'h1);
    sendFrame(1'b0, 1'b0, {1'b0, 8'($urandom)});
    drain;
    rdChk(OFS_STATUS, 32'h7, 32'h3);
    check({31'h0, irq}, 32'h1);
    sendFrame(1'b0, 1'b0, {1'b0, 8'($urandom)});
    rdChk(OFS_STATUS, 32'h2, 32'h0);
    check({31'h0, irq}, 32'h1);
    rdChk(OFS_IFLAG, 32'h1, 32'h1);
    @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    drain;
    check({31'h0, irq}, 32'h1);
    wrReg(OFS_IMASK, 32'h0);
    @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    // A deselected transfer must leave the mask alone
    hsel <= 1'b0;
    wrReg(OFS_IMASK, 32'h1);
    hsel <= 1'b1;
    rdChk(OFS_IMASK, 32'h1, 32'h0);
    rdChk(OFS_IFLAG, 32'h1, 32'h1);
    nineBits <= 1'b1;
    for (int b = 0; b < 2; b++)
    begin
      d = 8'($urandom);
      wrReg(OFS_CONTROL, {30'h0, b[0], 1'b1});
      sendFrame(1'b0, b[0], {~b[0], d});
      drain;
      sendFrame(1'b1, ~b[0], {~b[0], d});
      drain;
    end
    wrReg(OFS_CONTROL, 32'h0);
    nineBits <= 1'b0;
    // Four and three quarter clocks a bit
    wrReg(OFS_DIVIDER, 32'h0000_03C0);
    periodX8 <= 16'h0026;
    repeat (2)
    begin
      sendFrame(1'b0, 1'b0, {1'b0, 8'($urandom)});
      sendFrame(1'b0, 1'b0, {1'b0, 8'($urandom)});
      drain;
    end
    wrReg(OFS_DIVIDER, 32'h0000_0F00);
    periodX8 <= 16'h0080;
    wrReg(OFS_TXBASIC, {24'h0, 8'($urandom)});
    for (int i = 0; i < 400 && txOut !== 1'b0; i++) @(posedge ref_clk);
    wrReg(OFS_COMMAND, 32'h2);
    repeat (3) @(posedge ref_clk);
    check({31'h0, txOut}, 32'h1);
    rdChk(OFS_STATUS, 32'h1, 32'h0);
    wrReg(OFS_COMMAND, 32'h1);
    wrReg(OFS_COMMAND, 32'h3);
    rdChk(OFS_STATUS, 32'h1, 32'h0);
    // inverted idle level; kept shorter than half a bit so the receiver sees a glitch
    wrReg(OFS_CONTROL, 32'h4);
    repeat (2) @(posedge ref_clk);
    check({31'h0, txOut}, 32'h0);
    wrReg(OFS_CONTROL, 32'h0);
    wrReg(OFS_COMMAND, 32'h1);
    repeat (300) @(posedge ref_clk);
    sendFrame(1'b0, 1'b0, {1'b0, 8'($urandom)});
    drain;
    give_verdict;
  end
endmodule // lpuart_tx_tb
